// ==== src/dac_pll_clock_config.sv ====
// Top of the clock path configuration block: register port, controls and ratio outputs.
// Assumes a master that issues single-cycle strobes synchronous to clk_i.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module dac_pll_clock_config
	import clk_cfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [clk_cfg_pkg::ADDR_W-1:0] addr_i,
	input wire logic [clk_cfg_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [clk_cfg_pkg::DATA_W-1:0] rdata_o,
	output logic sample_clock_cross_en_o,
	output logic reference_clock_input_cross_en_o,
	output logic pll_en_o,
	output logic manual_band_en_o,
	output logic [5:0] vco_band_o,
	output logic [1:0] loop_bw_o,
	output logic [4:0] pump_current_o,
	output logic cross_point_en_o,
	output logic [clk_cfg_pkg::RATIO_W-1:0] controller_clock_divider_o,
	output logic [clk_cfg_pkg::RATIO_W-1:0] vco_output_divider_o,
	output logic [clk_cfg_pkg::RATIO_W-1:0] loop_feedback_divider_o
);
	cfg_bus_if bus ();

	// Address decode into register index.
	wire hit_rx = (addr_i == ADDR_RX);
	wire hit_en = (addr_i == ADDR_PLL_EN);
	wire hit_loop = (addr_i == ADDR_LOOP);
	wire hit_div = (addr_i == ADDR_DIV);
	wire hit = hit_rx | hit_en | hit_loop | hit_div;
	wire [1:0] sel = hit_en ? 2'h1 : hit_loop ? 2'h2 : hit_div ? 2'h3 : 2'h0;
	assign bus.wsel = sel;
	assign bus.wen = ce_i & wr_i & hit;
	assign bus.wdata = wdata_i;

	cfg_reg_store u_store (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.bus(bus)
	);

	wire [DATA_W-1:0] r_rx = bus.regs[0];
	wire [DATA_W-1:0] r_en = bus.regs[1];
	wire [DATA_W-1:0] r_loop = bus.regs[2];
	wire [DATA_W-1:0] r_div = bus.regs[3];
	// Unmapped addresses read as zero.
	wire [DATA_W-1:0] rdata_d = hit ? bus.regs[sel] : '0;

	// Read data stands for the one cycle after the strobe.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= rd_i ? rdata_d : '0;
		end
	end

	// Controls follow their register fields one cycle later.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sample_clock_cross_en_o <= RST_RX[RX_SCLK_BIT];
			reference_clock_input_cross_en_o <= RST_RX[RX_RCLK_BIT];
			pll_en_o <= RST_PLL_EN[PLL_EN_BIT];
			manual_band_en_o <= RST_PLL_EN[MANUAL_BIT];
			vco_band_o <= RST_PLL_EN[BAND_HI:0];
			loop_bw_o <= RST_LOOP[BW_HI:BW_LO];
			pump_current_o <= RST_LOOP[CP_HI:0];
			cross_point_en_o <= RST_DIV[XPT_BIT];
		end else if (ce_i) begin
			sample_clock_cross_en_o <= r_rx[RX_SCLK_BIT];
			reference_clock_input_cross_en_o <= r_rx[RX_RCLK_BIT];
			pll_en_o <= r_en[PLL_EN_BIT];
			manual_band_en_o <= r_en[MANUAL_BIT];
			vco_band_o <= r_en[BAND_HI:0];
			loop_bw_o <= r_loop[BW_HI:BW_LO];
			pump_current_o <= r_loop[CP_HI:0];
			cross_point_en_o <= r_div[XPT_BIT];
		end
	end

	ratio_decode u_dec (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.ctl_code_i(r_div[CTL_DIV_HI:CTL_DIV_LO]),
		.vco_code_i(r_div[VCO_DIV_HI:VCO_DIV_LO]),
		.loop_code_i(r_div[LOOP_DIV_HI:0]),
		.ctl_ratio_o(controller_clock_divider_o),
		.vco_ratio_o(vco_output_divider_o),
		.loop_ratio_o(loop_feedback_divider_o)
	);

	// Checks tying outputs to the written register values.
	sequence s_write(logic [ADDR_W-1:0] a);
		ce_i && wr_i && addr_i == a;
	endsequence
	property p_sclk;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_RX) ##1 ce_i |=> sample_clock_cross_en_o == $past(wdata_i[RX_SCLK_BIT], 2);
	endproperty
	a_sclk: assert property (p_sclk) else $error("sample cross enable wrong");
	property p_rclk;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_RX) ##1 ce_i |=>
			reference_clock_input_cross_en_o == $past(wdata_i[RX_RCLK_BIT], 2);
	endproperty
	a_rclk: assert property (p_rclk) else $error("reference cross enable wrong");
	property p_pll_en;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_PLL_EN) ##1 ce_i |=> pll_en_o == $past(wdata_i[PLL_EN_BIT], 2);
	endproperty
	a_pll_en: assert property (p_pll_en) else $error("pll enable wrong");
	property p_band;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_PLL_EN) ##1 ce_i |=> vco_band_o == $past(wdata_i[BAND_HI:0], 2);
	endproperty
	a_band: assert property (p_band) else $error("band wrong");
	property p_bw;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_LOOP) ##1 ce_i |=> loop_bw_o == $past(wdata_i[BW_HI:BW_LO], 2);
	endproperty
	a_bw: assert property (p_bw) else $error("bandwidth wrong");
	property p_cp;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_LOOP) ##1 ce_i |=> pump_current_o == $past(wdata_i[CP_HI:0], 2);
	endproperty
	a_cp: assert property (p_cp) else $error("pump current wrong");
	property p_ctl_div;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_DIV) ##1 ce_i |=>
			controller_clock_divider_o == (RATIO_2 << $past(wdata_i[CTL_DIV_HI:CTL_DIV_LO], 2));
	endproperty
	a_ctl_div: assert property (p_ctl_div) else $error("controller divider wrong");
	property p_xpt;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_DIV) ##1 ce_i |=> cross_point_en_o == $past(wdata_i[XPT_BIT], 2);
	endproperty
	a_xpt: assert property (p_xpt) else $error("cross point enable wrong");
	property p_vco;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_DIV) ##1 ce_i ##0 $past(wdata_i[VCO_DIV_HI]) |=> vco_output_divider_o == RATIO_4;
	endproperty
	a_vco: assert property (p_vco) else $error("vco divider wrong");
	property p_loop;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_DIV) ##1 ce_i ##0 $past(wdata_i[LOOP_DIV_HI])
			|=> loop_feedback_divider_o ==
			($past(wdata_i[LOOP_DIV_HI:0], 2) == 2'h2 ? RATIO_8 : RATIO_16);
	endproperty
	a_loop: assert property (p_loop) else $error("loop divider wrong");
	property p_rd;
		@(posedge clk_i) disable iff (!reset_n_i)
		ce_i && rd_i && !wr_i && addr_i == ADDR_DIV ##0 $past(ce_i) |=> rdata_o == $past(r_div);
	endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");

	// A read strobe taken at a given address.
	sequence s_read(logic [ADDR_W-1:0] a);
		ce_i && rd_i && addr_i == a;
	endsequence

	// A taken write followed by the enabled edge that moves it onto the outputs.
	sequence s_settle(logic [ADDR_W-1:0] a);
		s_write(a) ##1 ce_i;
	endsequence

	property p_manual;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_settle(ADDR_PLL_EN) |=> manual_band_en_o == $past(wdata_i[MANUAL_BIT], 2);
	endproperty
	a_manual: assert property (p_manual) else $error("manual band enable wrong");

	property p_vco_low;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_settle(ADDR_DIV) ##0 !$past(wdata_i[VCO_DIV_HI]) |=>
			vco_output_divider_o == ($past(wdata_i[VCO_DIV_LO], 2) ? RATIO_2 : RATIO_1);
	endproperty
	a_vco_low: assert property (p_vco_low) else $error("low vco divider code wrong");

	property p_loop_low;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_settle(ADDR_DIV) ##0 !$past(wdata_i[LOOP_DIV_HI]) |=>
			loop_feedback_divider_o ==
			($past(wdata_i[LOOP_DIV_HI:0], 2) == 2'h1 ? RATIO_4 : RATIO_2);
	endproperty
	a_loop_low: assert property (p_loop_low) else $error("low loop divider code wrong");

	// A read right behind a write sees the new byte with its unused bits cleared.
	property p_back_rx;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_RX) ##1 s_read(ADDR_RX) |=>
			rdata_o == ($past(wdata_i, 2) & MASK_RX);
	endproperty
	a_back_rx: assert property (p_back_rx) else $error("receiver readback wrong");

	property p_back_en;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_PLL_EN) ##1 s_read(ADDR_PLL_EN) |=>
			rdata_o == ($past(wdata_i, 2) & MASK_PLL_EN);
	endproperty
	a_back_en: assert property (p_back_en) else $error("pll enable readback wrong");

	property p_back_loop;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_LOOP) ##1 s_read(ADDR_LOOP) |=>
			rdata_o == ($past(wdata_i, 2) & MASK_LOOP);
	endproperty
	a_back_loop: assert property (p_back_loop) else $error("loop readback wrong");

	property p_back_div;
		@(posedge clk_i) disable iff (!reset_n_i)
		s_write(ADDR_DIV) ##1 s_read(ADDR_DIV) |=>
			rdata_o == ($past(wdata_i, 2) & MASK_DIV);
	endproperty
	a_back_div: assert property (p_back_div) else $error("divider readback wrong");

	// The first edge after reset is released still shows the reset settings.
	property p_rst_sclk;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> sample_clock_cross_en_o == RST_RX[RX_SCLK_BIT];
	endproperty
	a_rst_sclk: assert property (p_rst_sclk) else $error("sample cross reset wrong");

	property p_rst_rclk;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> reference_clock_input_cross_en_o == RST_RX[RX_RCLK_BIT];
	endproperty
	a_rst_rclk: assert property (p_rst_rclk) else $error("reference cross reset wrong");

	property p_rst_pll_en;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> pll_en_o == RST_PLL_EN[PLL_EN_BIT];
	endproperty
	a_rst_pll_en: assert property (p_rst_pll_en) else $error("pll enable reset wrong");

	property p_rst_manual;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> manual_band_en_o == RST_PLL_EN[MANUAL_BIT];
	endproperty
	a_rst_manual: assert property (p_rst_manual) else $error("manual band reset wrong");

	property p_rst_band;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> vco_band_o == RST_PLL_EN[BAND_HI:0];
	endproperty
	a_rst_band: assert property (p_rst_band) else $error("band reset wrong");

	property p_rst_bw;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> loop_bw_o == RST_LOOP[BW_HI:BW_LO];
	endproperty
	a_rst_bw: assert property (p_rst_bw) else $error("bandwidth reset wrong");

	property p_rst_cp;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> pump_current_o == RST_LOOP[CP_HI:0];
	endproperty
	a_rst_cp: assert property (p_rst_cp) else $error("pump current reset wrong");

	property p_rst_ctl;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> controller_clock_divider_o == RATIO_16;
	endproperty
	a_rst_ctl: assert property (p_rst_ctl) else $error("controller divider reset wrong");

	property p_rst_xpt;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> cross_point_en_o == RST_DIV[XPT_BIT];
	endproperty
	a_rst_xpt: assert property (p_rst_xpt) else $error("cross point reset wrong");

	property p_rst_vco;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> vco_output_divider_o == RATIO_4;
	endproperty
	a_rst_vco: assert property (p_rst_vco) else $error("vco divider reset wrong");

	property p_rst_loop;
		@(posedge clk_i) disable iff (!reset_n_i)
		$rose(reset_n_i) |-> loop_feedback_divider_o == RATIO_4;
	endproperty
	a_rst_loop: assert property (p_rst_loop) else $error("loop divider reset wrong");

	// A low clock enable freezes every control, so nothing may move across that edge.
	property p_hold_sclk;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(sample_clock_cross_en_o);
	endproperty
	a_hold_sclk: assert property (p_hold_sclk) else $error("sample cross moved while frozen");

	property p_hold_rclk;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(reference_clock_input_cross_en_o);
	endproperty
	a_hold_rclk: assert property (p_hold_rclk) else $error("reference cross moved while frozen");

	property p_hold_pll_en;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(pll_en_o);
	endproperty
	a_hold_pll_en: assert property (p_hold_pll_en) else $error("pll enable moved while frozen");

	property p_hold_manual;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(manual_band_en_o);
	endproperty
	a_hold_manual: assert property (p_hold_manual) else $error("manual band moved while frozen");

	property p_hold_band;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(vco_band_o);
	endproperty
	a_hold_band: assert property (p_hold_band) else $error("band moved while frozen");

	property p_hold_bw;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(loop_bw_o);
	endproperty
	a_hold_bw: assert property (p_hold_bw) else $error("bandwidth moved while frozen");

	property p_hold_cp;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(pump_current_o);
	endproperty
	a_hold_cp: assert property (p_hold_cp) else $error("pump current moved while frozen");

	property p_hold_ctl;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(controller_clock_divider_o);
	endproperty
	a_hold_ctl: assert property (p_hold_ctl) else $error("controller divider moved while frozen");

	property p_hold_xpt;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(cross_point_en_o);
	endproperty
	a_hold_xpt: assert property (p_hold_xpt) else $error("cross point moved while frozen");

	property p_hold_vco;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(vco_output_divider_o);
	endproperty
	a_hold_vco: assert property (p_hold_vco) else $error("vco divider moved while frozen");

	property p_hold_loop;
		@(posedge clk_i) disable iff (!reset_n_i)
		!ce_i |=> $stable(loop_feedback_divider_o);
	endproperty
	a_hold_loop: assert property (p_hold_loop) else $error("loop divider moved while frozen");
endmodule // dac_pll_clock_config

// ==== pkg/clk_cfg_pkg.sv ====
// Constants, register map and field layout of the clock path configuration block.
// Assumes a plain register port with 8-bit data and a single clock.
package clk_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_RX = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_PLL_EN = 8'h0A;
	localparam logic [ADDR_W-1:0] ADDR_LOOP = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_DIV = 8'h0D;
	localparam logic [DATA_W-1:0] RST_RX = 8'h30;
	localparam logic [DATA_W-1:0] RST_PLL_EN = 8'h40;
	localparam logic [DATA_W-1:0] RST_LOOP = 8'hD1;
	localparam logic [DATA_W-1:0] RST_DIV = 8'hD9;
	localparam logic [DATA_W-1:0] MASK_RX = 8'h30;
	localparam logic [DATA_W-1:0] MASK_PLL_EN = 8'hFF;
	localparam logic [DATA_W-1:0] MASK_LOOP = 8'hDF;
	localparam logic [DATA_W-1:0] MASK_DIV = 8'hDF;
	localparam int RX_SCLK_BIT = 5;
	localparam int RX_RCLK_BIT = 4;
	localparam int PLL_EN_BIT = 7;
	localparam int MANUAL_BIT = 6;
	localparam int BAND_HI = 5;
	localparam int BW_HI = 7;
	localparam int BW_LO = 6;
	localparam int CP_HI = 4;
	localparam int CTL_DIV_HI = 7;
	localparam int CTL_DIV_LO = 6;
	localparam int XPT_BIT = 4;
	localparam int VCO_DIV_HI = 3;
	localparam int VCO_DIV_LO = 2;
	localparam int LOOP_DIV_HI = 1;
	localparam int RATIO_W = 5;
	localparam logic [RATIO_W-1:0] RATIO_1 = 5'h01;
	localparam logic [RATIO_W-1:0] RATIO_2 = 5'h02;
	localparam logic [RATIO_W-1:0] RATIO_4 = 5'h04;
	localparam logic [RATIO_W-1:0] RATIO_8 = 5'h08;
	localparam logic [RATIO_W-1:0] RATIO_16 = 5'h10;
	localparam int N_REGS = 4;
	typedef logic [1:0] code2_t;
endpackage

// ==== pkg/cfg_bus_if.sv ====
// Internal carrier between the top and its register store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface cfg_bus_if;
	import clk_cfg_pkg::*;
	logic [1:0] wsel;
	logic wen;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] regs [N_REGS];
	modport store (input wsel, input wen, input wdata, output regs);
	modport user (output wsel, output wen, output wdata, input regs);
endinterface

// ==== src/cfg_reg_store.sv ====
// Register store holding the four configuration bytes with their reset values.
// Assumes writes are decoded by the caller and gated by the clock enable.
`timescale 1ns/1ps
module cfg_reg_store
	import clk_cfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	cfg_bus_if.store bus
);
	localparam logic [DATA_W-1:0] RST [N_REGS] = '{RST_RX, RST_PLL_EN, RST_LOOP, RST_DIV};
	localparam logic [DATA_W-1:0] MSK [N_REGS] = '{MASK_RX, MASK_PLL_EN, MASK_LOOP, MASK_DIV};
	// One byte per register; unused bits are masked to zero on write.
	for (genvar g = 0; g < N_REGS; g++) begin : g_reg
		logic [DATA_W-1:0] q;
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				q <= RST[g];
			end else if (bus.wen && bus.wsel == 2'(g)) begin
				q <= bus.wdata & MSK[g];
			end
		end
		assign bus.regs[g] = q;
	end
endmodule // cfg_reg_store

// ==== src/ratio_decode.sv ====
// Registered decode of the three divider codes into plain ratios.
// Assumes codes come from the register store.
`timescale 1ns/1ps
module ratio_decode
	import clk_cfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input clk_cfg_pkg::code2_t ctl_code_i,
	input clk_cfg_pkg::code2_t vco_code_i,
	input clk_cfg_pkg::code2_t loop_code_i,
	output logic [RATIO_W-1:0] ctl_ratio_o,
	output logic [RATIO_W-1:0] vco_ratio_o,
	output logic [RATIO_W-1:0] loop_ratio_o
);
	// Power-of-two table shared by controller and loop dividers.
	function automatic logic [RATIO_W-1:0] pow_ratio(input code2_t c);
		case (c)
			2'h0: pow_ratio = RATIO_2;
			2'h1: pow_ratio = RATIO_4;
			2'h2: pow_ratio = RATIO_8;
			default: pow_ratio = RATIO_16;
		endcase
	endfunction
	wire [RATIO_W-1:0] ctl_d = pow_ratio(ctl_code_i);
	wire [RATIO_W-1:0] loop_d = pow_ratio(loop_code_i);
	// Codes 10 and 11 of the VCO divider both mean four.
	wire [RATIO_W-1:0] vco_d = (vco_code_i == 2'h0) ? RATIO_1 :
		(vco_code_i == 2'h1) ? RATIO_2 : RATIO_4;
	// Ratios start from reset register defaults.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl_ratio_o <= RATIO_16;
			vco_ratio_o <= RATIO_4;
			loop_ratio_o <= RATIO_4;
		end else if (ce_i) begin
			ctl_ratio_o <= ctl_d;
			vco_ratio_o <= vco_d;
			loop_ratio_o <= loop_d;
		end
	end
endmodule // ratio_decode

// ==== tb/test_dac_pll_clock_config.sv ====
// Self-checking bench for the clock path configuration block.
// Assumes the block answers reads one cycle after the strobe and updates controls two edges on.
`timescale 1ns/1ps
module test_dac_pll_clock_config;
	import clk_cfg_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic [ADDR_W-1:0] addr_i = 8'h00;
	logic [DATA_W-1:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [DATA_W-1:0] rdata_o;
	logic sc_x, rc_x, pll_en, man_en, xpt_en, rd_pend = 1'b0;
	logic [5:0] band;
	logic [1:0] bw;
	logic [4:0] pump;
	logic [RATIO_W-1:0] ctl_r, vco_r, loop_r;
	logic [DATA_W-1:0] m [4];
	logic [DATA_W-1:0] mk [4];
	logic [DATA_W-1:0] exp_q [$];
	int failures = 0;
	int total_checks = 0;

	dac_pll_clock_config dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.sample_clock_cross_en_o(sc_x), .reference_clock_input_cross_en_o(rc_x),
		.pll_en_o(pll_en), .manual_band_en_o(man_en), .vco_band_o(band), .loop_bw_o(bw),
		.pump_current_o(pump), .cross_point_en_o(xpt_en), .controller_clock_divider_o(ctl_r),
		.vco_output_divider_o(vco_r), .loop_feedback_divider_o(loop_r));

	// Free-running clock at 10 MHz.
	always #50 clk_i = ~clk_i;

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic int idx(input logic [7:0] a);
		case (a)
			ADDR_RX: return 0;
			ADDR_PLL_EN: return 1;
			ADDR_LOOP: return 2;
			ADDR_DIV: return 3;
			default: return -1;
		endcase
	endfunction

	// Puts the mirror back to the reset contents.
	task automatic mirror_reset();
		m = '{RST_RX, RST_PLL_EN, RST_LOOP, RST_DIV};
	endtask

	// One-cycle write; the mirror follows only when the write is taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		if (ce_i === 1'b1 && idx(a) >= 0) m[idx(a)] = d & mk[idx(a)];
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// One-cycle read; the expected byte is queued for the monitor when taken.
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		if (ce_i === 1'b1) exp_q.push_back(idx(a) >= 0 ? m[idx(a)] : 8'h00);
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask

	// Write with the read of the same address right behind it, no gap between strobes.
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		if (ce_i === 1'b1 && idx(a) >= 0) m[idx(a)] = d & mk[idx(a)];
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		if (ce_i === 1'b1) exp_q.push_back(idx(a) >= 0 ? m[idx(a)] : 8'h00);
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask

	// Waits for the controls to follow a write, then compares them with the mirror.
	task automatic check_outs();
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		check(8'(sc_x), 8'(m[0][RX_SCLK_BIT]));
		check(8'(rc_x), 8'(m[0][RX_RCLK_BIT]));
		check(8'(pll_en), 8'(m[1][PLL_EN_BIT]));
		check(8'(man_en), 8'(m[1][MANUAL_BIT]));
		check(8'(band), 8'(m[1][BAND_HI:0]));
		check(8'(bw), 8'(m[2][BW_HI:BW_LO]));
		check(8'(pump), 8'(m[2][CP_HI:0]));
		check(8'(ctl_r), 8'(RATIO_2 << m[3][CTL_DIV_HI:CTL_DIV_LO]));
		check(8'(xpt_en), 8'(m[3][XPT_BIT]));
		check(8'(vco_r), 8'(m[3][3:2] == 2'b00 ? RATIO_1 :
			m[3][3:2] == 2'b01 ? RATIO_2 : RATIO_4));
		check(8'(loop_r), 8'(RATIO_2 << m[3][LOOP_DIV_HI:0]));
	endtask

	// Notes when a taken read should answer, then compares the byte with the oldest note.
	always @(posedge clk_i) rd_pend <= reset_n_i && ce_i && rd_i;
	always @(negedge clk_i) begin
		if (rd_pend) begin
			if (exp_q.size() > 0) check(rdata_o, exp_q.pop_front());
			else check(rdata_o, 8'hXX);
		end
	end

	// Cuts a hang short.
	initial begin
		#(100 * 5000);
		failures++;
		end_sim();
	end

	// Main sequence.
	initial begin
		mk = '{MASK_RX, MASK_PLL_EN, MASK_LOOP, MASK_DIV};
		mirror_reset();
		void'($urandom(24758));
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		check_outs();
		foreach (m[i]) rd(i == 0 ? ADDR_RX : i == 1 ? ADDR_PLL_EN : i == 2 ? ADDR_LOOP : ADDR_DIV);
		$display("test reset values done");
		repeat (24) begin
			wr_rd($urandom % 4 == 0 ? ADDR_RX : 8'h0A + 8'($urandom % 4), 8'($urandom));
			check_outs();
			rd(addr_i);
		end
		rd(8'h0B);
		$display("test random writes done");
		// The reference clock is taken as slow enough that every controller code is legal.
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_DIV, {2'(c), 2'b00, 2'(c), 2'(c)});
			check_outs();
		end
		$display("test divider codes done");
		@(posedge clk_i);
		ce_i <= 1'b0;
		wr(ADDR_DIV, ~m[3]);
		rd(ADDR_DIV);
		check_outs();
		@(posedge clk_i);
		ce_i <= 1'b1;
		rd(ADDR_DIV);
		$display("test clock enable done");
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		mirror_reset();
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		check_outs();
		rd(ADDR_LOOP);
		repeat (3) @(posedge clk_i);
		$display("test second reset done");
		end_sim();
	end
endmodule // test_dac_pll_clock_config
